// >>> hdl/csr_defs.svh
/*
 special register subset: offsets, field positions, reset values.
 assumes inclusion by bare name from the design; the package does not include it.
*/
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH
// register indices; byte address is four times the index
`define CSR_IDX_WBPC 8'h0c
`define CSR_IDX_XCFG 8'h0d
`define CSR_IDX_HINT 8'h0e
`define CSR_IDX_OPC 8'h80
`define CSR_IDX_OPA 8'h81
`define CSR_IDX_OPB 8'h82
`define CSR_IDX_MDX 8'h83
`define CSR_IDX_EXPC 8'h90
`define CSR_IDX_CTRL 8'h91
`define CSR_PC_LSB 2
`define CSR_PS_LSB 8
`define CSR_PS_MSB 9
`define CSR_TAG_MSB 7
`define CSR_HINT_LSB 1
`define CSR_HINT_MSB 6
`define CSR_PTR_LSB 2
`define CSR_PTR_MSB 9
`define CSR_FREEZE_BIT 0
`define CSR_RST_WORD 32'h0000_0000
`define CSR_XCFG_MASK 32'h0000_03ff
`define CSR_PTR_MASK 32'h0000_03fc
`define CSR_PC_MASK 32'hffff_fffc
`endif

// >>> hdl/csr_pkg.sv
/*
 types for the special register subset.
 assumes csr_defs.svh is on the include path.
*/
package csr_pkg;
    typedef enum logic [1:0] {
        CSR_PS_1K = 2'h0,
        CSR_PS_2K = 2'h1,
        CSR_PS_4K = 2'h2,
        CSR_PS_8K = 2'h3
    } csr_page_e;
    typedef enum logic [2:0] {
        CSR_IDLE = 3'h1,
        CSR_MUL = 3'h2,
        CSR_DIV = 3'h4
    } csr_md_e;
    typedef struct packed {
        logic [31:0] wbPc;
        logic [31:0] exPc;
        logic [9:0] xcfg;
        logic [5:0] hint;
        logic [7:0] ptrC;
        logic [7:0] ptrA;
        logic [7:0] ptrB;
        logic [31:0] mdx;
        logic freeze;
        logic [31:0] prdata;
        csr_md_e mdState;
        logic [1:0] pageSize;
    } csr_state_s;
endpackage : csr_pkg

// >>> hdl/csr_special_regs.sv
/*
 special register subset of a 32-bit processor: pipeline pc capture,
 translation config and replacement hint, indirect operand pointers,
 multiply/divide extension. apb slave for software access.
 assumes pipeline, mmu and mul/div unit drive the hardware strobes
 synchronously to clk.
*/
`timescale 1ns/100ps
`include "csr_defs.svh"
module csr_special_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pipeline capture
    input wire logic wbAdvance,
    input wire logic [31:0] wbInstrAddr,
    input wire logic exAdvance,
    input wire logic [31:0] exInstrAddr,
    input wire logic trapTaken,
    // translation
    input wire logic [7:0] entryOwnerTag,
    output logic tagMatch,
    output csr_pkg::csr_page_e pageSizeSelect,
    input wire logic tlbMiss,
    input wire logic protViolation,
    input wire logic [5:0] replacementIndex,
    // operand selection
    input wire logic [7:0] instrCSelect,
    input wire logic [7:0] instrASelect,
    input wire logic [7:0] instrBSelect,
    output logic [7:0] operandC,
    output logic [7:0] operandA,
    output logic [7:0] operandB,
    // multiply/divide unit; capture freeze flag
    input wire logic mdStart,
    input wire logic mdIsDivide,
    input wire logic [31:0] mdLoadValue,
    input wire logic mdDone,
    input wire logic [31:0] mdResultLow,
    output logic [31:0] muldivExtension,
    output logic mdBusy,
    output logic freezeCapture
);
    // the upper-bit check on paddr needs at least one bit above bit 9
    if (ADDR_W < 11) begin : g_bad_addr_w
        $error("ADDR_W too small for register map");
    end

    csr_pkg::csr_state_s stReg;
    csr_pkg::csr_state_s stNext;
    logic access;
    logic wrEn;
    logic mapped;
    logic [7:0] idx;

    function automatic logic [7:0] pick_reg(
        input logic [7:0] field,
        input logic [7:0] ptr
    );
        // absolute number, never offset by the stack pointer
        pick_reg = (field == 8'h00) ? ptr : field;
    endfunction : pick_reg

    function automatic logic [31:0] ptr_word(input logic [7:0] ptr);
        ptr_word = {22'h0, ptr, 2'h0};
    endfunction : ptr_word

    assign idx = paddr[9:2];
    assign access = psel && penable;
    assign wrEn = access && pwrite;
    assign pready = access;
    assign mapped = (paddr[1:0] == 2'h0)
        && (paddr[ADDR_W-1:10] == '0)
        && (idx == `CSR_IDX_WBPC || idx == `CSR_IDX_XCFG
            || idx == `CSR_IDX_HINT || idx == `CSR_IDX_OPC
            || idx == `CSR_IDX_OPA || idx == `CSR_IDX_OPB
            || idx == `CSR_IDX_MDX || idx == `CSR_IDX_EXPC
            || idx == `CSR_IDX_CTRL);
    // hint is read-only, so a write to it is refused too
    assign pslverr = access
        && (!mapped || (pwrite && idx == `CSR_IDX_HINT));

    always_comb begin
        stNext = stReg;
        // pipeline capture, write-back and execute stages
        if (wbAdvance && !stReg.freeze) begin
            // on a trap the last advance holds the write-back instruction
            stNext.wbPc = wbInstrAddr & `CSR_PC_MASK;
        end
        if (exAdvance && !stReg.freeze) begin
            stNext.exPc = exInstrAddr & `CSR_PC_MASK;
        end
        // miss and violation share the update path
        if (tlbMiss || protViolation) begin
            stNext.hint = replacementIndex;
        end
        unique case (stReg.mdState)
            csr_pkg::CSR_IDLE: begin
                if (mdStart) begin
                    stNext.mdx = mdLoadValue;
                    stNext.mdState = mdIsDivide ? csr_pkg::CSR_DIV
                                                : csr_pkg::CSR_MUL;
                end
            end
            csr_pkg::CSR_MUL: begin
                if (mdDone) begin
                    stNext.mdx = mdResultLow;
                    stNext.mdState = csr_pkg::CSR_IDLE;
                end
            end
            csr_pkg::CSR_DIV: begin
                if (mdDone) begin
                    stNext.mdx = mdResultLow;
                    stNext.mdState = csr_pkg::CSR_IDLE;
                end
            end
            default: begin
                stNext.mdState = csr_pkg::CSR_IDLE;
            end
        endcase
        // page size takes effect one cycle after the field is written
        stNext.pageSize = stReg.xcfg[`CSR_PS_MSB:`CSR_PS_LSB];
        // software writes win over hardware updates in the same cycle
        if (wrEn && mapped) begin
            unique case (idx)
                `CSR_IDX_WBPC: stNext.wbPc = pwdata & `CSR_PC_MASK;
                `CSR_IDX_EXPC: stNext.exPc = pwdata & `CSR_PC_MASK;
                `CSR_IDX_XCFG: stNext.xcfg = pwdata[9:0];
                `CSR_IDX_OPC:
                    stNext.ptrC = pwdata[`CSR_PTR_MSB:`CSR_PTR_LSB];
                `CSR_IDX_OPA:
                    stNext.ptrA = pwdata[`CSR_PTR_MSB:`CSR_PTR_LSB];
                `CSR_IDX_OPB:
                    stNext.ptrB = pwdata[`CSR_PTR_MSB:`CSR_PTR_LSB];
                `CSR_IDX_MDX: stNext.mdx = pwdata;
                `CSR_IDX_CTRL:
                    stNext.freeze = pwdata[`CSR_FREEZE_BIT];
                default: begin
                end
            endcase
        end
        stNext.prdata = stReg.prdata;
        // captured at the end of setup so the word stands while pready is
        // high; a hardware update in the access cycle shows on the next read
        if (psel && !penable && !pwrite) begin
            unique case (idx)
                `CSR_IDX_WBPC: stNext.prdata = stReg.wbPc;
                `CSR_IDX_EXPC: stNext.prdata = stReg.exPc;
                `CSR_IDX_XCFG: stNext.prdata = {22'h0, stReg.xcfg};
                `CSR_IDX_HINT:
                    stNext.prdata = {25'h0, stReg.hint, 1'b0};
                `CSR_IDX_OPC: stNext.prdata = ptr_word(stReg.ptrC);
                `CSR_IDX_OPA: stNext.prdata = ptr_word(stReg.ptrA);
                `CSR_IDX_OPB: stNext.prdata = ptr_word(stReg.ptrB);
                `CSR_IDX_MDX: stNext.prdata = stReg.mdx;
                `CSR_IDX_CTRL: stNext.prdata = {31'h0, stReg.freeze};
                default: stNext.prdata = `CSR_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stReg <= '{wbPc: `CSR_RST_WORD, exPc: `CSR_RST_WORD,
                       xcfg: 10'h000, hint: 6'h00, ptrC: 8'h00,
                       ptrA: 8'h00, ptrB: 8'h00, mdx: `CSR_RST_WORD,
                       freeze: 1'b0, prdata: `CSR_RST_WORD,
                       mdState: csr_pkg::CSR_IDLE, pageSize: 2'h0};
        end else begin
            stReg <= stNext;
        end
    end

    // read word is a flop loaded in setup, valid through the access cycle
    assign prdata = stReg.prdata;
    // tag compare is combinational against the live entry
    assign tagMatch =
        (entryOwnerTag == stReg.xcfg[`CSR_TAG_MSB:0]);
    assign pageSizeSelect = csr_pkg::csr_page_e'(stReg.pageSize);
    assign operandC = pick_reg(instrCSelect, stReg.ptrC);
    assign operandA = pick_reg(instrASelect, stReg.ptrA);
    assign operandB = pick_reg(instrBSelect, stReg.ptrB);
    assign muldivExtension = stReg.mdx;
    assign mdBusy = (stReg.mdState != csr_pkg::CSR_IDLE);
    assign freezeCapture = stReg.freeze;
    logic unusedTrap;
    assign unusedTrap = trapTaken;
endmodule : csr_special_regs

// >>> testbench/csr_special_regs_assertions.sv
/*
 port checker for csr_special_regs.
 assumes the hand-over byte addresses; bound at file foot.
*/
`timescale 1ns/100ps
module csr_special_regs_assertions #(parameter int ADDR_W = 12) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] instrCSelect,
    input wire logic [7:0] operandC,
    input wire logic mdStart,
    input wire logic mdDone,
    input wire logic mdBusy,
    input wire logic [31:0] mdLoadValue,
    input wire logic [31:0] mdResultLow,
    input wire logic [31:0] muldivExtension,
    input wire csr_pkg::csr_page_e pageSizeSelect,
    input wire logic freezeCapture
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire wr = psel && penable && pwrite;
    // software write wins, so those cycles are left out
    wire mdxWr = wr && paddr == 12'h20c;
    chk_ready_zero: assert property (pready == (psel && penable))
        else $error("pready not zero wait");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_hint_ro: assert property (wr && paddr == 12'h38 |-> pslverr)
        else $error("hint write accepted");
    chk_opc_field: assert property (instrCSelect != 8'h0 |->
        operandC == instrCSelect) else $error("operand c not field");
    chk_mdx_load: assert property (!mdBusy && mdStart && !mdxWr
        |=> muldivExtension == $past(mdLoadValue)) else $error("mdx load");
    chk_mdx_done: assert property (mdBusy && mdDone && !mdxWr
        |=> muldivExtension == $past(mdResultLow)) else $error("mdx done");
    chk_page_late: assert property (wr && paddr == 12'h34 |=>
        $stable(pageSizeSelect) ##1 pageSizeSelect == $past(pwdata[9:8], 2))
        else $error("page size timing");
    chk_freeze_set: assert property (wr && paddr == 12'h244 |=>
        freezeCapture == $past(pwdata[0])) else $error("freeze bit");
    cover property (wr && paddr == 12'h34);
    cover property (mdDone);
    cover property (pslverr);
endmodule : csr_special_regs_assertions
bind csr_special_regs csr_special_regs_assertions #(.ADDR_W(ADDR_W))
    u_chk (.*);

// >>> testbench/testbench.sv
/*
 self-checking bench for csr_special_regs over apb and strobes.
 assumes zero-wait apb; read data taken at the edge where pready is high.
*/
`timescale 1ns/100ps
module testbench;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, wbInstrAddr = 0, exInstrAddr = 0;
    logic [31:0] mdLoadValue = 0, mdResultLow = 0, prdata, muldivExtension;
    logic wbAdvance = 0, exAdvance = 0, trapTaken = 0, tlbMiss = 0;
    logic protViolation = 0, mdStart = 0, mdIsDivide = 0, mdDone = 0;
    logic [7:0] entryOwnerTag = 0, instrCSelect = 0, instrASelect = 0;
    logic [7:0] instrBSelect = 0, operandC, operandA, operandB;
    logic [5:0] replacementIndex = 0;
    logic pready, pslverr, tagMatch, mdBusy, freezeCapture;
    csr_pkg::csr_page_e pageSizeSelect;
    logic [32:0] expQ[$];
    logic [31:0] r, v, mon, pv[3];
    int n_fail = 0, checks_done = 0, seed = 45648;
    logic [11:0] adr[6] = '{12'h30, 12'h34, 12'h200, 12'h204, 12'h208,
                            12'h20c};
    logic [31:0] msk[6] = '{32'hfffffffc, 32'h3ff, 32'h3fc, 32'h3fc, 32'h3fc,
                            32'hffffffff};
    csr_special_regs u_dut (.*);
    always #2.5 clk = ~clk;
    task cmp(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [32:0] e);
        @(posedge clk);
        expQ.push_back(e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask : apb
    // result of each access, taken at the edge where pready stands high
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            mon = (!pwrite && !pslverr) ? prdata : 32'h0;
            cmp({pslverr, mon}, expQ.pop_front());
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        #50000;
        n_fail++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1;
        for (int i = 0; i < 6; i++) begin
            apb(0, adr[i], 0, 33'h0);
            v = $random(seed);
            apb(1, adr[i], v, 33'h0);
            apb(0, adr[i], 0, {1'b0, v & msk[i]});
        end
        apb(0, 12'h38, 0, 33'h0);
        apb(1, 12'h38, 1, {1'b1, 32'h0});
        apb(0, 12'h100, 0, {1'b1, 32'h0});
        for (int f = 0; f < 2; f++) begin
            apb(1, 12'h244, f, 33'h0);
            v = $random(seed);
            @(posedge clk);
            wbAdvance <= 1;
            exAdvance <= 1;
            trapTaken <= f;
            wbInstrAddr <= v;
            exInstrAddr <= ~v;
            @(posedge clk);
            wbAdvance <= 0;
            exAdvance <= 0;
            trapTaken <= 0;
            cmp(freezeCapture, f);
            if (f == 0) r = v;
            apb(0, 12'h30, 0, {1'b0, r & 32'hfffffffc});
            apb(0, 12'h240, 0, {1'b0, ~r & 32'hfffffffc});
        end
        for (int p = 0; p < 4; p++) begin
            v = ($random(seed) & 32'hff) | (p << 8);
            apb(1, 12'h34, v, 33'h0);
            entryOwnerTag <= v[7:0];
            repeat (2) @(posedge clk);
            #1 cmp(pageSizeSelect, p);
            cmp(tagMatch, 1);
            @(posedge clk);
            entryOwnerTag <= ~v[7:0];
            @(posedge clk);
            #1 cmp(tagMatch, 0);
        end
        for (int k = 0; k < 2; k++) begin
            v = $random(seed);
            @(posedge clk);
            tlbMiss <= !k;
            protViolation <= k;
            replacementIndex <= v[5:0];
            @(posedge clk);
            tlbMiss <= 0;
            protViolation <= 0;
            apb(0, 12'h38, 0, {26'h0, v[5:0], 1'b0});
        end
        for (int i = 0; i < 3; i++) begin
            pv[i] = $random(seed);
            apb(1, adr[2+i], pv[i], 33'h0);
        end
        for (int z = 0; z < 2; z++) begin
            v = $random(seed) | 32'h01010101;
            @(posedge clk);
            instrCSelect <= z ? v[7:0] : 8'h0;
            instrASelect <= z ? v[15:8] : 8'h0;
            instrBSelect <= z ? v[23:16] : 8'h0;
            @(posedge clk);
            #1 cmp(operandC, z ? v[7:0] : pv[0][9:2]);
            cmp(operandA, z ? v[15:8] : pv[1][9:2]);
            cmp(operandB, z ? v[23:16] : pv[2][9:2]);
        end
        for (int d = 0; d < 2; d++) begin
            v = $random(seed);
            r = $random(seed);
            @(posedge clk);
            mdStart <= 1;
            mdIsDivide <= d;
            mdLoadValue <= v;
            @(posedge clk);
            mdStart <= 0;
            mdDone <= 1;
            mdResultLow <= r;
            #1 cmp(muldivExtension, v);
            cmp(mdBusy, 1);
            @(posedge clk);
            mdDone <= 0;
            #1 cmp(muldivExtension, r);
            cmp(mdBusy, 0);
            apb(0, 12'h20c, 0, {1'b0, r});
        end
        repeat (2) @(posedge clk);
        test_done;
    end
endmodule : testbench
